/* pkg/cmc_pkg.sv */
package cmc_pkg;
	// array geometry of the 32-macrocell part
	localparam int NUM_BLK = 2;
	localparam int MC_PER_BLK = 16;
	localparam int NUM_MC = 32;
	localparam int NUM_GCLK = 4;
	localparam int NUM_BCLK = 4;
	localparam int TERM_BUS_W = 4;
	localparam int NUM_GOE_PIN = 2;
	localparam int GOE_BUS_W = 2;
	localparam int NUM_OE_SRC = 6;
	localparam int MC_CFG_W = 10;
	localparam int OE_CFG_W = 25;
	// register byte offsets
	localparam logic [9:0] REG_CTRL = 10'h000;
	localparam logic [9:0] REG_TERM = 10'h004;
	localparam logic [9:0] REG_CLKGEN = 10'h008;
	localparam logic [9:0] REG_OECFG = 10'h00C;
	localparam logic [9:0] REG_STATUS = 10'h010;
	localparam logic [9:0] REG_MCQ = 10'h014;
	localparam logic [2:0] REG_MCCFG_PAGE = 3'h2;
	// field positions
	localparam int CTRL_RELOAD_BIT = 0;
	localparam int CLKGEN_FLD_W = 4;
	localparam int CLKGEN_INV_BIT = 2;
	localparam int OE_INV_LSB = 8;
	localparam int OE_SEL_LSB = 16;
	localparam int OE_SEL_W = 3;
	localparam int MC_CE_LSB = 0;
	localparam int MC_BCLK_LSB = 2;
	localparam int MC_INIT_LSB = 4;
	localparam int MC_SWAP_BIT = 6;
	localparam int MC_SR_EN_BIT = 7;
	localparam int MC_LATCH_BIT = 8;
	localparam int MC_LATCH_HI_BIT = 9;
	// values after reset
	localparam logic [1:0] TERM_RST = 2'h1;
	localparam logic [31:0] CLKGEN_RST = 32'h32103210;
	localparam logic [OE_CFG_W-1:0] OECFG_RST = 25'h0000000;
	localparam logic [MC_CFG_W-1:0] MCCFG_RST = 10'h000;
	// power-up delay before block clocks may run
	localparam int CLK_PERIOD_NS = 10;
	localparam int INIT_DELAY_NS = 1000;
	localparam int INIT_DELAY_CYC =
		(INIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [15:0] INIT_LAST = 16'(INIT_DELAY_CYC - 1);
	typedef enum logic [1:0] {
		CMC_CE_INIT, CMC_CE_INIT_N, CMC_CE_SHCLK, CMC_CE_HIGH
	} cmc_ce_t;
	typedef enum logic [1:0] {
		CMC_INIT_NONE, CMC_INIT_RESET, CMC_INIT_SET, CMC_INIT_OFF
	} cmc_init_t;
	typedef enum logic [1:0] {
		CMC_TERM_NONE, CMC_TERM_PULLUP, CMC_TERM_PULLDOWN, CMC_TERM_KEEPER
	} cmc_term_t;
	typedef enum logic {CMC_WAIT, CMC_RUN} cmc_state_t;
endpackage : cmc_pkg

/* verilog/cmc_top.sv */
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - each macrocell clock enable picks init term, its inverse, shared clock, or high
// - one init term per block reaches every macrocell register of that block
// - each macrocell may use two own terms as its set and reset
// - per-macrocell option swaps reset and preset roles
// - power-up loads one only for set-on-block-init after swap, else zero
// - four global clock pins, each also readable as a plain logic input
// - each block builds four block clocks from true or inverted global clocks
// - one shared input termination setting, pull-up after reset
// - output-enable bus is two bits on this 32-macrocell part
// - bus sources are a four-bit term enable bus plus two enable pins
// - every bus source has its own optional inversion
// - per-block enable term fans onto term bus bits through four fuses
// - latch mode selects transparent on gate low or gate high
// - external reset pin clears macrocell registers without a clock edge
module cmc_top (
	// clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RESETN,
	// register bus
	input wire logic [9:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] I_AVS_WRITEDATA,
	input wire logic [3:0] I_AVS_BYTEENABLE,
	output logic [31:0] O_AVS_READDATA,
	output logic O_AVS_WAITREQUEST,
	// device pins
	input wire logic [cmc_pkg::NUM_GCLK-1:0] I_GCLK,
	input wire logic [cmc_pkg::NUM_GOE_PIN-1:0] I_GOE_PIN,
	input wire logic I_EXT_RESETN,
	// logic array terms
	input wire logic [cmc_pkg::NUM_MC-1:0] I_MC_D,
	input wire logic [cmc_pkg::NUM_MC-1:0] I_PT_INIT_ENABLE,
	input wire logic [cmc_pkg::NUM_MC-1:0] I_PT_SET,
	input wire logic [cmc_pkg::NUM_MC-1:0] I_PT_RST,
	input wire logic [cmc_pkg::NUM_BLK-1:0] I_BLK_INIT,
	input wire logic [cmc_pkg::NUM_BLK-1:0] I_SHARED_TERM_CLOCK,
	input wire logic [cmc_pkg::NUM_BLK-1:0] I_BLK_OE_TERM,
	// results
	output logic [cmc_pkg::NUM_MC-1:0] O_MC_Q,
	output logic [cmc_pkg::NUM_GCLK-1:0] O_GRP_GCLK,
	output logic [cmc_pkg::GOE_BUS_W-1:0] O_GOE_BUS,
	output logic [1:0] O_TERM_MODE
);
	import cmc_pkg::*;

	function automatic logic [31:0] wmerge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] be);
		logic [31:0] r;
		r = old_v;
		for (int k = 0; k < 4; k++) begin
			if (be[k]) begin
				r[k*8 +: 8] = new_v[k*8 +: 8];
			end
		end
		return r;
	endfunction : wmerge

	function automatic logic init_sets(input logic [1:0] mode,
		input logic swap);
		return (mode == CMC_INIT_SET && !swap) ||
			(mode == CMC_INIT_RESET && swap);
	endfunction : init_sets

	function automatic logic init_resets(input logic [1:0] mode,
		input logic swap);
		return (mode == CMC_INIT_RESET && !swap) ||
			(mode == CMC_INIT_SET && swap);
	endfunction : init_resets

	function automatic logic [3:0] settle(input logic [3:0] s2,
		input logic [3:0] s3, input logic [3:0] lvl);
		return (s2 & ~(s2 ^ s3)) | (lvl & (s2 ^ s3));
	endfunction : settle

	// registers
	logic ack_r;
	logic wait_r;
	logic [31:0] rdata_r;
	logic [1:0] term_r;
	logic [31:0] clkgen_r;
	logic [OE_CFG_W-1:0] oecfg_r;
	logic [MC_CFG_W-1:0] mccfg_r [NUM_MC];
	cmc_state_t state_r;
	logic [15:0] cnt_r;
	logic [NUM_GCLK-1:0] gclk_s1_r, gclk_s2_r, gclk_s3_r, gclk_lvl_r;
	logic [3:0] goe_s1_r, goe_s2_r, goe_s3_r, goe_lvl_r;
	logic [NUM_BLK*NUM_BCLK-1:0] bclk_prev_r;
	logic [GOE_BUS_W-1:0] goe_bus_r;
	logic [NUM_MC-1:0] mc_q_r;
	logic [2:0] xrst_sync_r;

	// bus decode
	wire req = I_AVS_READ | I_AVS_WRITE;
	wire wr_go = I_AVS_WRITE & ack_r;
	wire is_mccfg = I_AVS_ADDRESS[9:7] == REG_MCCFG_PAGE;
	wire [4:0] mc_idx = I_AVS_ADDRESS[6:2];
	wire wr_ctrl = wr_go && I_AVS_ADDRESS == REG_CTRL;
	wire wr_term = wr_go && I_AVS_ADDRESS == REG_TERM;
	wire wr_clkgen = wr_go && I_AVS_ADDRESS == REG_CLKGEN;
	wire wr_oecfg = wr_go && I_AVS_ADDRESS == REG_OECFG;
	wire wr_mccfg = wr_go && is_mccfg;
	wire [31:0] wd = I_AVS_WRITEDATA;
	wire [3:0] be = I_AVS_BYTEENABLE;
	wire reload = wr_ctrl && be[0] && wd[CTRL_RELOAD_BIT];
	wire run = state_r == CMC_RUN;
	wire [31:0] term_w = wmerge({30'h0, term_r}, wd, be);
	wire [31:0] clkgen_w = wmerge(clkgen_r, wd, be);
	wire [31:0] oecfg_w = wmerge({7'h0, oecfg_r}, wd, be);
	wire [31:0] mccfg_w = wmerge({22'h0, mccfg_r[mc_idx]}, wd, be);
	wire [TERM_BUS_W-1:0] term_bus;
	wire [31:0] status_w = {15'h0, run, 6'h0, goe_bus_r,
		term_bus, gclk_lvl_r};
	wire [31:0] rd_mux =
		(I_AVS_ADDRESS == REG_CTRL) ? {31'h0, run} :
		(I_AVS_ADDRESS == REG_TERM) ? {30'h0, term_r} :
		(I_AVS_ADDRESS == REG_CLKGEN) ? clkgen_r :
		(I_AVS_ADDRESS == REG_OECFG) ? {7'h0, oecfg_r} :
		(I_AVS_ADDRESS == REG_STATUS) ? status_w :
		(I_AVS_ADDRESS == REG_MCQ) ? mc_q_r :
		is_mccfg ? {22'h0, mccfg_r[mc_idx]} : 32'h00000000;

	// one wait cycle, then a one-cycle answer
	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			ack_r <= 1'b0;
			wait_r <= 1'b1;
			rdata_r <= 32'h00000000;
		end else begin
			ack_r <= req & ~ack_r;
			// own flop so the pin has no gate behind it
			wait_r <= ~(req & ~ack_r);
			if (I_AVS_READ && !ack_r) begin
				rdata_r <= rd_mux;
			end
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			term_r <= TERM_RST;
			clkgen_r <= CLKGEN_RST;
			oecfg_r <= OECFG_RST;
			for (int i = 0; i < NUM_MC; i++) begin
				mccfg_r[i] <= MCCFG_RST;
			end
		end else begin
			if (wr_term) begin
				term_r <= term_w[1:0];
			end
			if (wr_clkgen) begin
				clkgen_r <= clkgen_w;
			end
			if (wr_oecfg) begin
				oecfg_r <= oecfg_w[OE_CFG_W-1:0];
			end
			if (wr_mccfg) begin
				mccfg_r[mc_idx] <= mccfg_w[MC_CFG_W-1:0];
			end
		end
	end

	// power-up delay; block clocks stay gated until it ends
	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			state_r <= CMC_WAIT;
			cnt_r <= 16'h0000;
		end else if (reload) begin
			state_r <= CMC_WAIT;
			cnt_r <= 16'h0000;
		end else if (state_r == CMC_WAIT) begin
			cnt_r <= cnt_r + 16'h0001;
			if (cnt_r == INIT_LAST) begin
				state_r <= CMC_RUN;
			end
		end
	end

	// pin synchronisers; a change counts once stages two and three agree
	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			gclk_s1_r <= 4'h0;
			gclk_s2_r <= 4'h0;
			gclk_s3_r <= 4'h0;
			gclk_lvl_r <= 4'h0;
			goe_s1_r <= 4'h0;
			goe_s2_r <= 4'h0;
			goe_s3_r <= 4'h0;
			goe_lvl_r <= 4'h0;
		end else begin
			gclk_s1_r <= I_GCLK;
			gclk_s2_r <= gclk_s1_r;
			gclk_s3_r <= gclk_s2_r;
			gclk_lvl_r <= settle(gclk_s2_r, gclk_s3_r, gclk_lvl_r);
			goe_s1_r <= {2'h0, I_GOE_PIN};
			goe_s2_r <= goe_s1_r;
			goe_s3_r <= goe_s2_r;
			goe_lvl_r <= settle(goe_s2_r, goe_s3_r, goe_lvl_r);
		end
	end

	// block clock generator
	wire [NUM_BLK*NUM_BCLK-1:0] bclk_lvl;
	wire [NUM_BLK*NUM_BCLK-1:0] bclk_edge;
	for (genvar c = 0; c < NUM_BLK * NUM_BCLK; c++) begin : g_bclk
		wire [3:0] fld = clkgen_r[c*CLKGEN_FLD_W +: CLKGEN_FLD_W];
		assign bclk_lvl[c] = gclk_lvl_r[fld[1:0]] ^ fld[CLKGEN_INV_BIT];
		assign bclk_edge[c] = run & bclk_lvl[c] & ~bclk_prev_r[c];
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			bclk_prev_r <= '0;
		end else begin
			bclk_prev_r <= bclk_lvl;
		end
	end

	// output-enable generation
	wire [TERM_BUS_W*NUM_BLK-1:0] fuse_hit;
	for (genvar j = 0; j < TERM_BUS_W; j++) begin : g_tbus
		for (genvar b = 0; b < NUM_BLK; b++) begin : g_blk
			assign fuse_hit[j*NUM_BLK+b] =
				I_BLK_OE_TERM[b] & oecfg_r[b*TERM_BUS_W+j];
		end
		assign term_bus[j] = |fuse_hit[j*NUM_BLK +: NUM_BLK];
	end
	wire [NUM_OE_SRC-1:0] oe_src = {goe_lvl_r[1:0], term_bus} ^
		oecfg_r[OE_INV_LSB +: NUM_OE_SRC];
	wire [GOE_BUS_W-1:0] goe_nxt;
	for (genvar j = 0; j < GOE_BUS_W; j++) begin : g_goe
		wire [2:0] sel = oecfg_r[OE_SEL_LSB+j*OE_SEL_W +: OE_SEL_W];
		assign goe_nxt[j] = (sel < 3'h6) ? oe_src[sel] : 1'b0;
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RESETN) begin
		if (!I_RESETN) begin
			goe_bus_r <= '0;
		end else begin
			goe_bus_r <= goe_nxt;
		end
	end

	// macrocells
	wire [NUM_MC-1:0] mc_q_nxt;
	for (genvar i = 0; i < NUM_MC; i++) begin : g_mc
		localparam int B = i / MC_PER_BLK;
		wire [MC_CFG_W-1:0] cfg = mccfg_r[i];
		wire [1:0] ce_sel = cfg[MC_CE_LSB +: 2];
		wire [1:0] mode = cfg[MC_INIT_LSB +: 2];
		wire swap = cfg[MC_SWAP_BIT];
		wire sr_en = cfg[MC_SR_EN_BIT];
		wire gate = bclk_lvl[B*NUM_BCLK+cfg[MC_BCLK_LSB +: 2]];
		wire edge_hit = bclk_edge[B*NUM_BCLK+cfg[MC_BCLK_LSB +: 2]];
		wire ce = (ce_sel == CMC_CE_INIT) ? I_PT_INIT_ENABLE[i] :
			(ce_sel == CMC_CE_INIT_N) ? ~I_PT_INIT_ENABLE[i] :
			(ce_sel == CMC_CE_SHCLK) ? I_SHARED_TERM_CLOCK[B] :
			1'b1;
		wire do_set = (I_BLK_INIT[B] & init_sets(mode, swap)) |
			(sr_en & (swap ? I_PT_RST[i] : I_PT_SET[i]));
		wire do_rst = (I_BLK_INIT[B] & init_resets(mode, swap)) |
			(sr_en & (swap ? I_PT_SET[i] : I_PT_RST[i]));
		wire open_l = cfg[MC_LATCH_BIT] & (gate == cfg[MC_LATCH_HI_BIT]);
		// reset beats set when both terms fire together
		assign mc_q_nxt[i] = !run ? init_sets(mode, swap) :
			do_rst ? 1'b0 :
			do_set ? 1'b1 :
			cfg[MC_LATCH_BIT] ? (open_l ? I_MC_D[i] : mc_q_r[i]) :
			(edge_hit & ce) ? I_MC_D[i] : mc_q_r[i];
	end

	// pin reset acts at once, no clock needed; release waits three
	// edges so no register leaves reset in a race with its clock
	wire mc_rst_n = I_RESETN & I_EXT_RESETN;
	wire mc_arst_n = xrst_sync_r[2];
	always_ff @(posedge I_CORE_CLK or negedge mc_rst_n) begin
		if (!mc_rst_n) begin
			xrst_sync_r <= 3'h0;
		end else begin
			xrst_sync_r <= {xrst_sync_r[1:0], 1'b1};
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge mc_arst_n) begin
		if (!mc_arst_n) begin
			mc_q_r <= '0;
		end else begin
			mc_q_r <= mc_q_nxt;
		end
	end

	assign O_AVS_READDATA = rdata_r;
	assign O_AVS_WAITREQUEST = wait_r;
	assign O_MC_Q = mc_q_r;
	assign O_GRP_GCLK = gclk_lvl_r;
	assign O_GOE_BUS = goe_bus_r;
	assign O_TERM_MODE = term_r;
endmodule : cmc_top
`default_nettype wire

/* test/cmc_top_props.sv */
`timescale 1ns/1ps
`default_nettype none
module cmc_top_props (
	// clock and reset
	input wire logic I_CORE_CLK,
	input wire logic I_RESETN,
	// register bus
	input wire logic [9:0] I_AVS_ADDRESS,
	input wire logic I_AVS_READ,
	input wire logic I_AVS_WRITE,
	input wire logic [31:0] O_AVS_READDATA,
	input wire logic O_AVS_WAITREQUEST,
	// pins and results
	input wire logic [3:0] I_GCLK,
	input wire logic I_EXT_RESETN,
	input wire logic [31:0] O_MC_Q,
	input wire logic [3:0] O_GRP_GCLK,
	input wire logic [1:0] O_TERM_MODE
);
	import cmc_pkg::*;
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RESETN);
	wire req = I_AVS_READ | I_AVS_WRITE;
	chk_wait_answer: assert property (
		req && O_AVS_WAITREQUEST |=> !O_AVS_WAITREQUEST) else $error("no answer");
	chk_wait_once: assert property (
		!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST) else $error("answer too long");
	chk_wait_cause: assert property (
		!O_AVS_WAITREQUEST |-> $past(req)) else $error("answer without request");
	chk_unmapped_zero: assert property (
		I_AVS_READ && !O_AVS_WAITREQUEST && I_AVS_ADDRESS == 10'h0F0
		|-> O_AVS_READDATA == 32'h0) else $error("unmapped read not zero");
	chk_rdata_hold: assert property (
		$changed(O_AVS_READDATA) |-> $past(I_AVS_READ)) else $error("data moved");
	chk_term_change: assert property (
		$changed(O_TERM_MODE) |-> $past(I_AVS_WRITE && !O_AVS_WAITREQUEST
		&& I_AVS_ADDRESS == REG_TERM)) else $error("termination moved");
	chk_gclk_follow: assert property (
		$stable(I_GCLK) [*6] |-> O_GRP_GCLK == I_GCLK) else $error("clock pin view");
	chk_xrst_clear: assert property (
		!I_EXT_RESETN |-> O_MC_Q == 32'h0) else $error("reset pin ignored");
	cover property (I_AVS_READ && !O_AVS_WAITREQUEST);
	cover property (I_AVS_WRITE && !O_AVS_WAITREQUEST);
	cover property (!I_EXT_RESETN);
endmodule : cmc_top_props
bind cmc_top cmc_top_props cmc_top_props_inst (.I_CORE_CLK, .I_RESETN,
	.I_AVS_ADDRESS, .I_AVS_READ, .I_AVS_WRITE, .O_AVS_READDATA,
	.O_AVS_WAITREQUEST, .I_GCLK, .I_EXT_RESETN, .O_MC_Q, .O_GRP_GCLK,
	.O_TERM_MODE);
`default_nettype wire

/* test/tb_cmc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_cmc_top;
	import cmc_pkg::*;
	logic clk = 0, rstn = 0, rd = 0, wr = 0, xrst = 1, wreq, en, eq = 0;
	logic [9:0] adr = '0;
	logic [31:0] wd = '0, rdat, q, d = '0, pinit = '0, pset = '0, prst = '0, r;
	logic [3:0] gclk = '0, global_routing_pool;
	logic [1:0] global_enable_pin = '0, binit = '0, shc = '0, boe = '0, oeb, tm;
	logic [31:0] expq[$];
	int fails = 0, n_tests = 0;
	initial forever #5 clk = ~clk;
	cmc_top cmc_top_inst (.I_CORE_CLK(clk), .I_RESETN(rstn), .I_AVS_ADDRESS(adr),
		.I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wd),
		.I_AVS_BYTEENABLE(4'hF), .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wreq),
		.I_GCLK(gclk), .I_GOE_PIN(global_enable_pin), .I_EXT_RESETN(xrst), .I_MC_D(d),
		.I_PT_INIT_ENABLE(pinit), .I_PT_SET(pset), .I_PT_RST(prst),
		.I_BLK_INIT(binit), .I_SHARED_TERM_CLOCK(shc), .I_BLK_OE_TERM(boe),
		.O_MC_Q(q), .O_GRP_GCLK(global_routing_pool), .O_GOE_BUS(oeb), .O_TERM_MODE(tm));
	task automatic cmp_out(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			fails++;
			$display("wrong value t=%0t got %h exp %h", $time, g, e);
		end
	endtask : cmp_out
	task automatic cmp_rd(input logic [31:0] g);
		cmp_out(g, expq.pop_front());
	endtask : cmp_rd
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask : idle
	// starts one edge late so a release and a new request never share a step
	task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] v);
		@(posedge clk);
		rd <= !w;
		wr <= w;
		adr <= a;
		wd <= v;
		do @(posedge clk); while (wreq !== 1'b0);
		rd <= 0;
		wr <= 0;
	endtask : xfer
	task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
		expq.push_back(e);
		xfer(0, a, 32'h0);
	endtask : rdchk
	// block clock 0 follows global clock 0 after the pin synchroniser
	task automatic tick;
		@(posedge clk) gclk[0] <= 1;
		idle(8);
		gclk[0] <= 0;
		idle(8);
	endtask : tick
	task automatic report_and_stop;
		$display("fails=%0d n_tests=%0d", fails, n_tests);
		if (fails == 0 && n_tests > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : report_and_stop
	always @(posedge clk) if (rd && wreq === 1'b0) cmp_rd(rdat);
	initial begin
		idle(3000);
		fails++;
		report_and_stop;
	end
	initial begin
		void'($urandom(84));
		idle(20);
		rstn <= 1;
		idle(1);
		cmp_out(32'(tm), 32'(TERM_RST));
		rdchk(REG_CLKGEN, CLKGEN_RST);
		for (int m = 0; m < 4; m++) begin
			xfer(1, REG_TERM, 32'(m));
			rdchk(REG_TERM, 32'(m));
			cmp_out(32'(tm), 32'(m));
		end
		xfer(1, 10'h0F0, 32'hFFFFFFFF);
		rdchk(10'h0F0, 32'h0);
		$display("register test done");
		idle(100);
		repeat (4) begin
			gclk <= 4'($urandom);
			idle(8);
			cmp_out(32'(global_routing_pool), 32'(gclk));
		end
		gclk <= 4'h0;
		idle(8);
		$display("clock pin test done");
		for (int s = 0; s < 4; s++) begin
			xfer(1, 10'h100, 32'(s));
			d[0] <= ~eq;
			pinit[0] <= 1'($urandom);
			shc[0] <= 1'($urandom);
			tick;
			en = s == 3 || (s == 2 && shc[0]) || (s == 1 && !pinit[0]) || (s == 0 && pinit[0]);
			if (en)
				eq = d[0];
			cmp_out(32'(q[0]), 32'(eq));
		end
		$display("enable test done");
		xfer(1, 10'h104, 32'h20);
		xfer(1, 10'h108, 32'h60);
		xfer(1, 10'h10C, 32'h50);
		xfer(1, REG_CTRL, 32'h1);
		idle(110);
		cmp_out(32'(q[4:1]), 32'h5);
		xfer(1, 10'h140, 32'h60);
		xfer(1, 10'h144, 32'h20);
		binit[1] <= 1;
		idle(3);
		cmp_out(32'(q[17:16]), 32'h2);
		binit[1] <= 0;
		$display("init test done");
		xfer(1, 10'h114, 32'h80);
		pset[5] <= 1;
		idle(3);
		cmp_out(32'(q[5]), 32'h1);
		pset[5] <= 0;
		prst[5] <= 1;
		idle(3);
		cmp_out(32'(q[5]), 32'h0);
		prst[5] <= 0;
		xrst <= 0;
		#2 cmp_out(q, 32'h0);
		@(posedge clk) xrst <= 1;
		$display("set reset test done");
		d[0] <= 0;
		d[6] <= 1;
		xfer(1, 10'h118, 32'h300);
		idle(3);
		cmp_out(32'(q[6]), 32'h0);
		gclk[0] <= 1;
		idle(6);
		cmp_out(32'(q[6]), 32'h1);
		d[6] <= 0;
		idle(2);
		cmp_out(32'(q[6]), 32'h0);
		gclk[0] <= 0;
		idle(6);
		d[6] <= 1;
		idle(3);
		cmp_out(32'(q[6]), 32'h0);
		xfer(1, 10'h118, 32'h100);
		idle(2);
		cmp_out(32'(q[6]), 32'h1);
		$display("latch test done");
		d[0] <= 1;
		xfer(1, REG_CLKGEN, 32'h32103214);
		idle(3);
		cmp_out(32'(q[0]), 32'h1);
		d[0] <= 0;
		tick;
		cmp_out(32'(q[0]), 32'h0);
		$display("clock invert test done");
		xfer(1, REG_OECFG, 32'h201011);
		repeat (6) begin
			r = $urandom;
			boe <= r[1:0];
			global_enable_pin <= r[3:2];
			idle(8);
			cmp_out(32'(oeb), 32'({~global_enable_pin[0], boe[0] | boe[1]}));
		end
		$display("enable bus test done");
		report_and_stop;
	end
endmodule : tb_cmc_top
`default_nettype wire
